/* File: core/tcpwm_chop.sv */
// Gate chopping carrier: toggles every (div+1) peripheral ticks.
// Assumes tick is a one-cycle enable at the peripheral rate.
module tcpwm_chop #(
  parameter int CW = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic enable,
  input wire logic [CW-1:0] div,
  output logic carrier_q
);
  logic [CW-1:0] cnt_q; // Ticks in the current half period

  // Divider and carrier toggle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      carrier_q <= 1'b1;
    end else if (!enable) begin
      // Idle carrier passes the gate signal unchanged
      cnt_q <= '0;
      carrier_q <= 1'b1;
    end else if (tick) begin
      if (cnt_q >= div) begin
        cnt_q <= '0;
        carrier_q <= !carrier_q;
      end else begin
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule : tcpwm_chop

/* File: core/tcpwm_map.svh */
// Register offsets, field positions and reset values of the PWM core.
// Assumes inclusion by bare name from the core's design files.
`ifndef TCPWM_MAP_SVH
`define TCPWM_MAP_SVH

// Byte offsets within the 256-byte register window
`define TCPWM_OFF_PERIOD 8'h00
`define TCPWM_OFF_DEADTIME 8'h04
`define TCPWM_OFF_MINPULSE 8'h08
`define TCPWM_OFF_GATE 8'h0c
`define TCPWM_OFF_DUTY_A 8'h10
`define TCPWM_OFF_DUTY_B 8'h14
`define TCPWM_OFF_DUTY_C 8'h18
`define TCPWM_OFF_SEGMENT 8'h1c
`define TCPWM_OFF_STATUS 8'h20

// Segment select fields: swap bit of phase A, off bits of phase A
`define TCPWM_SEG_SWAP_A 8
`define TCPWM_SEG_OFF_AH 4
`define TCPWM_SEG_OFF_AL 5
`define TCPWM_SEG_W 9

// Gate chop fields
`define TCPWM_GATE_HI_EN 8
`define TCPWM_GATE_LO_EN 9
`define TCPWM_GATE_W 10

// Status fields
`define TCPWM_ST_RUN 0
`define TCPWM_ST_TRIPPED 1
`define TCPWM_ST_POL 2
`define TCPWM_ST_TRIP_PIN 3
`define TCPWM_ST_DUTY_LSB 4

// Reset values
`define TCPWM_SEG_RST 9'h000
`define TCPWM_GATE_RST 10'h000

`endif

/* File: core/tcpwm_phase.sv */
// Edge timing of one inverter phase, purely combinational.
// Assumes the caller registers the result and supplies a count below period.
module tcpwm_phase #(
  parameter int W = 12
) (
  input wire logic [W-1:0] cnt,
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] duty,
  input wire logic [W-1:0] dtime,
  input wire logic [W-1:0] min_pulse,
  output logic hi_on,
  output logic lo_on
);
  localparam int SW = W + 3;
  logic signed [SW-1:0] c2; // Doubled count, sampled mid-tick
  logic signed [SW-1:0] per_s; // Period, signed
  logic signed [SW-1:0] on_hi; // High-side width after deadtime
  logic signed [SW-1:0] lo_w; // Low-side width after deadtime
  logic signed [SW-1:0] pd_s; // Minimum pulse, signed
  logic del_hi; // High pulse dropped
  logic del_lo; // Low pulse dropped

  // Windows mirrored about the period centre
  always_comb begin
    c2 = signed'({2'b00, cnt, 1'b1});
    per_s = signed'({3'b000, period});
    pd_s = signed'({3'b000, min_pulse});
    on_hi = signed'({3'b000, duty}) - signed'({3'b000, dtime});
    lo_w = per_s - signed'({3'b000, duty}) - signed'({3'b000, dtime});
    del_hi = (on_hi <= 0) || (on_hi < pd_s);
    del_lo = (lo_w <= 0) || (lo_w < pd_s);
    if (del_hi) begin
      // Low side saturated on
      hi_on = 1'b0;
      lo_on = 1'b1;
    end else if (del_lo) begin
      // High side saturated on, no deadtime at the cycle edge
      hi_on = 1'b1;
      lo_on = 1'b0;
    end else begin
      // Symmetric high window, low outside a gap of deadtime
      // Half-open windows keep exact tick widths for odd values too
      hi_on = (c2 >= per_s - on_hi) && (c2 < per_s + on_hi);
      lo_on = (c2 < lo_w) || (c2 >= per_s + per_s - lo_w);
    end
  end
endmodule : tcpwm_phase

/* File: core/tcpwm_pkg.sv */
// Types shared by the PWM core files.
// Assumes nothing of its surroundings.
package tcpwm_pkg;
  // Run state of the switching timer
  typedef enum logic [1:0] {
    TCPWM_IDLE,
    TCPWM_RUN,
    TCPWM_TRIP
  } tcpwm_state_t;
endpackage : tcpwm_pkg

/* File: core/tcpwm_top.sv */
// Three-phase center-aligned PWM core with an AHB-Lite register slave.
// Assumes one hclk domain, one bus master, and asynchronous trip/polarity pins.
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`include "tcpwm_map.svh"
module tcpwm_top #(
  parameter int W = 12, // Period, duty, deadtime width
  parameter int CW = 6 // Chop divider field width
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fault_trip_in,
  input wire logic output_polarity_in,
  output logic phase_a_high_out,
  output logic phase_a_low_out,
  output logic phase_b_high_out,
  output logic phase_b_low_out,
  output logic phase_c_high_out,
  output logic phase_c_low_out,
  output logic cycle_sync_out,
  output logic trip_event_out
);
  // Bus state
  logic acc_w; // Address phase taken
  logic wr_pend_q; // Write data phase pending
  logic [7:0] wr_addr_q; // Write offset
  logic [31:0] rd_d; // Read mux
  // Pin synchronisers
  logic trip_m_q, trip_s_q, trip_d_q;
  logic pol_m_q, pol_s_q;
  // Shadow registers
  logic [W-1:0] per_sh_q, dt_sh_q, pd_sh_q;
  logic [W-1:0] duty_sh_q [3];
  logic [2:0] dw_q; // Duty written flags
  logic [`TCPWM_SEG_W-1:0] seg_sh_q;
  logic [`TCPWM_GATE_W-1:0] gate_q;
  logic period_ok_q; // Period written since reset or trip
  logic trip_flag_q; // Sticky trip record
  // Active timing set
  logic [W-1:0] per_act_q, dt_act_q, pd_act_q;
  logic [W-1:0] duty_act_q [3];
  logic [`TCPWM_SEG_W-1:0] seg_act_q;
  // Timer
  tcpwm_pkg::tcpwm_state_t state_q;
  logic tick_q; // Peripheral clock enable
  logic [W-1:0] cnt_q;
  logic load_w; // Cycle start
  logic run_w;
  logic [2:0] tu_hi, tu_lo; // Timing unit outputs
  logic carrier_w;
  logic [2:0] pin_hi_q, pin_lo_q;
  logic [5:0] pins_w;

  // Zero-wait slave, always OKAY
  assign acc_w = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Write address capture for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc_w && hwrite;
      if (acc_w) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      `TCPWM_OFF_PERIOD: rd_d[W-1:0] = per_sh_q;
      `TCPWM_OFF_DEADTIME: rd_d[W-1:0] = dt_sh_q;
      `TCPWM_OFF_MINPULSE: rd_d[W-1:0] = pd_sh_q;
      `TCPWM_OFF_GATE: rd_d[`TCPWM_GATE_W-1:0] = gate_q;
      `TCPWM_OFF_DUTY_A: rd_d[W-1:0] = duty_sh_q[0];
      `TCPWM_OFF_DUTY_B: rd_d[W-1:0] = duty_sh_q[1];
      `TCPWM_OFF_DUTY_C: rd_d[W-1:0] = duty_sh_q[2];
      `TCPWM_OFF_SEGMENT: rd_d[`TCPWM_SEG_W-1:0] = seg_sh_q;
      `TCPWM_OFF_STATUS: begin
        rd_d[`TCPWM_ST_RUN] = run_w;
        rd_d[`TCPWM_ST_TRIPPED] = trip_flag_q;
        rd_d[`TCPWM_ST_POL] = pol_s_q;
        rd_d[`TCPWM_ST_TRIP_PIN] = trip_s_q;
        rd_d[`TCPWM_ST_DUTY_LSB +: 3] = dw_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc_w && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // Two-stage synchronisers for the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_m_q <= 1'b1;
      trip_s_q <= 1'b1;
      trip_d_q <= 1'b1;
      pol_m_q <= 1'b0;
      pol_s_q <= 1'b0;
    end else begin
      trip_m_q <= fault_trip_in;
      trip_s_q <= trip_m_q;
      trip_d_q <= trip_s_q;
      pol_m_q <= output_polarity_in;
      pol_s_q <= pol_m_q;
    end
  end

  // Trip event pulse and sticky record, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_event_out <= 1'b0;
      trip_flag_q <= 1'b0;
    end else begin
      trip_event_out <= trip_d_q && !trip_s_q;
      if (trip_d_q && !trip_s_q) begin
        trip_flag_q <= 1'b1;
      end else if (wr_pend_q && wr_addr_q == `TCPWM_OFF_STATUS
                   && hwdata[`TCPWM_ST_TRIPPED]) begin
        trip_flag_q <= 1'b0;
      end
    end
  end

  // Shadow registers, wiped while the trip pin is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_sh_q <= '0;
      dt_sh_q <= '0;
      pd_sh_q <= '0;
      gate_q <= `TCPWM_GATE_RST;
      seg_sh_q <= `TCPWM_SEG_RST;
      period_ok_q <= 1'b0;
    end else if (!trip_s_q) begin
      per_sh_q <= '0;
      dt_sh_q <= '0;
      pd_sh_q <= '0;
      gate_q <= `TCPWM_GATE_RST;
      seg_sh_q <= `TCPWM_SEG_RST;
      period_ok_q <= 1'b0;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `TCPWM_OFF_PERIOD: begin
          per_sh_q <= hwdata[W-1:0];
          period_ok_q <= 1'b1;
        end
        `TCPWM_OFF_DEADTIME: dt_sh_q <= hwdata[W-1:0];
        `TCPWM_OFF_MINPULSE: pd_sh_q <= hwdata[W-1:0];
        `TCPWM_OFF_GATE: gate_q <= hwdata[`TCPWM_GATE_W-1:0];
        `TCPWM_OFF_SEGMENT: seg_sh_q <= hwdata[`TCPWM_SEG_W-1:0];
        default: period_ok_q <= period_ok_q;
      endcase
    end
  end

  // Peripheral tick at half the bus clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= !tick_q;
    end
  end

  // Cycle start: first start after period write, then each wrap
  assign load_w = tick_q && trip_s_q
    && ((state_q == tcpwm_pkg::TCPWM_IDLE && period_ok_q)
     || (state_q == tcpwm_pkg::TCPWM_RUN
         && cnt_q == per_act_q - {{(W-1){1'b0}}, 1'b1}));
  assign run_w = (state_q == tcpwm_pkg::TCPWM_RUN);

  // Run state; trip overrides all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= tcpwm_pkg::TCPWM_IDLE;
    end else if (!trip_s_q) begin
      state_q <= tcpwm_pkg::TCPWM_TRIP;
    end else begin
      case (state_q)
        tcpwm_pkg::TCPWM_IDLE: begin
          if (load_w) begin
            state_q <= tcpwm_pkg::TCPWM_RUN;
          end
        end
        tcpwm_pkg::TCPWM_RUN: state_q <= tcpwm_pkg::TCPWM_RUN;
        tcpwm_pkg::TCPWM_TRIP: state_q <= tcpwm_pkg::TCPWM_IDLE;
        default: state_q <= tcpwm_pkg::TCPWM_IDLE;
      endcase
    end
  end

  // Period counter on the peripheral tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (!run_w || load_w) begin
      cnt_q <= '0;
    end else if (tick_q) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Shadow to active transfer at cycle start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_act_q <= '0;
      dt_act_q <= '0;
      pd_act_q <= '0;
      seg_act_q <= `TCPWM_SEG_RST;
    end else if (load_w) begin
      per_act_q <= per_sh_q;
      dt_act_q <= dt_sh_q;
      pd_act_q <= pd_sh_q;
      seg_act_q <= seg_sh_q;
    end
  end

  // Sync pulse during the first tick of a cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_sync_out <= 1'b0;
    end else begin
      cycle_sync_out <= run_w && cnt_q == '0 && trip_s_q;
    end
  end

  // Shared chop carrier
  tcpwm_chop #(.CW(CW)) u_chop (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick_q),
    .enable(gate_q[`TCPWM_GATE_HI_EN] || gate_q[`TCPWM_GATE_LO_EN]),
    .div(gate_q[CW-1:0]),
    .carrier_q(carrier_w)
  );

  // Per-phase duty shadows, timing and output stages
  for (genvar g = 0; g < 3; g++) begin : g_ph
    logic hi_sel, lo_sel, act_hi, act_lo;

    // Duty shadow, written flag, active duty; a write beats the clear
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        duty_sh_q[g] <= '0;
        dw_q[g] <= 1'b0;
        duty_act_q[g] <= '0;
      end else if (!trip_s_q) begin
        duty_sh_q[g] <= '0;
        dw_q[g] <= 1'b0;
        duty_act_q[g] <= '0;
      end else begin
        if (load_w && (&dw_q)) begin
          duty_act_q[g] <= duty_sh_q[g];
        end
        if (wr_pend_q && wr_addr_q == `TCPWM_OFF_DUTY_A + 8'(4 * g)) begin
          duty_sh_q[g] <= hwdata[W-1:0];
          dw_q[g] <= 1'b1;
        end else if (load_w && (&dw_q)) begin
          dw_q[g] <= 1'b0;
        end
      end
    end

    // Edge timing from duty, period, deadtime and minimum pulse
    tcpwm_phase #(.W(W)) u_phase (
      .cnt(cnt_q),
      .period(per_act_q),
      .duty(duty_act_q[g]),
      .dtime(dt_act_q),
      .min_pulse(pd_act_q),
      .hi_on(tu_hi[g]),
      .lo_on(tu_lo[g])
    );

    // Crossover, per-pin disable, chopping
    always_comb begin
      hi_sel = seg_act_q[`TCPWM_SEG_SWAP_A - g] ? tu_lo[g] : tu_hi[g];
      lo_sel = seg_act_q[`TCPWM_SEG_SWAP_A - g] ? tu_hi[g] : tu_lo[g];
      act_hi = run_w && hi_sel && !seg_act_q[`TCPWM_SEG_OFF_AH - 2 * g]
        && (!gate_q[`TCPWM_GATE_HI_EN] || carrier_w);
      act_lo = run_w && lo_sel && !seg_act_q[`TCPWM_SEG_OFF_AL - 2 * g]
        && (!gate_q[`TCPWM_GATE_LO_EN] || carrier_w);
    end

    // Polarity applied in the output flop
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pin_hi_q[g] <= 1'b0;
        pin_lo_q[g] <= 1'b0;
      end else begin
        pin_hi_q[g] <= act_hi ^ !pol_s_q;
        pin_lo_q[g] <= act_lo ^ !pol_s_q;
      end
    end

    chk_pair_excl: assert property (@(posedge hclk) disable iff (!hresetn)
      !(tu_hi[g] && tu_lo[g])) else $error("pair both active");
  end

  assign phase_a_high_out = pin_hi_q[0];
  assign phase_a_low_out = pin_lo_q[0];
  assign phase_b_high_out = pin_hi_q[1];
  assign phase_b_low_out = pin_lo_q[1];
  assign phase_c_high_out = pin_hi_q[2];
  assign phase_c_low_out = pin_lo_q[2];
  assign pins_w = {pin_hi_q, pin_lo_q};

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_sync_start: assert property ((load_w && per_sh_q > 12'h001)
    |-> ##2 cycle_sync_out ##1 cycle_sync_out ##1 !cycle_sync_out)
    else $error("sync not at cycle start");
  chk_trip_stop: assert property (!trip_s_q |=> state_q == tcpwm_pkg::TCPWM_TRIP
    ##1 pins_w == {6{!$past(pol_s_q)}}) else $error("trip left outputs on");
  chk_idle_level: assert property ((hresetn && !run_w) |=> pins_w == {6{!$past(pol_s_q)}})
    else $error("idle level wrong");
  chk_need_period: assert property ((!run_w && !period_ok_q) |=> !run_w)
    else $error("ran without period");
  chk_duty_hold: assert property ((!$past(load_w) && $past(trip_s_q))
    |-> $stable(duty_act_q[0]))
    else $error("duty changed mid cycle");
  chk_all_three: assert property (($changed(duty_act_q[1]) && $past(trip_s_q))
    |-> $past(&dw_q))
    else $error("duty loaded before all written");
  chk_seg_start: assert property (!$past(load_w) |-> $stable(seg_act_q))
    else $error("segment changed mid cycle");
  chk_tick_rate: assert property ((run_w && !tick_q && !load_w) |=> $stable(cnt_q))
    else $error("count moved off tick");
  chk_delete_low: assert property ((run_w && dt_act_q >= duty_act_q[0])
    |-> (!tu_hi[0] && tu_lo[0])) else $error("narrow pulse kept");
  chk_read_one: assert property ((acc_w && !hwrite && haddr[7:0] == `TCPWM_OFF_PERIOD)
    |=> hreadyout && hrdata[W-1:0] == $past(per_sh_q)) else $error("read slow");

  cov_wrap: cover property (load_w && run_w);
  cov_trip: cover property (run_w ##1 !trip_s_q);
  cov_swap: cover property (run_w && seg_act_q[`TCPWM_SEG_SWAP_A]);
  cov_chop: cover property (run_w && gate_q[`TCPWM_GATE_HI_EN] && !carrier_w);

  // Size strobe accepted but only whole words are decoded
  logic unused_w;
  assign unused_w = ^{hsize, haddr[31:8], trip_d_q};
endmodule : tcpwm_top

/* File: tb/tcpwm_drive_model.sv */
// Gate drive side model: hardwired polarity, fault comparator, pin meters.
// Assumes it samples the core's gate pins on hclk rising edges.
module tcpwm_drive_model (
  input wire logic hclk,
  input wire logic pol_set, // Polarity strap chosen by the bench
  input wire logic fault_set, // Fault comparator level, low = fault
  input wire logic [5:0] pins, // {ah, al, bh, bl, ch, cl}
  input wire logic sync,
  input wire logic trip_event,
  output logic output_polarity_in,
  output logic fault_trip_in,
  output logic [2:0][15:0] hi_last, // Active high-side clocks per cycle
  output logic [15:0] lo_last, // Active phase A low-side clocks per cycle
  output logic [15:0] both_last, // Clocks with a pair both active
  output logic [15:0] rise_last, // Phase A high-side turn-ons per cycle
  output logic [15:0] len_last, // Clocks between sync starts
  output logic [15:0] sw_last, // Sync pulse width in clocks
  output logic [15:0] tev_cnt, // Trip event pulses seen
  output logic [15:0] cycles // Sync starts seen
);
  logic [2:0] hi_act; // Per phase high side active
  logic [2:0] lo_act; // Per phase low side active
  logic sync_q;
  logic hi_q;
  logic [2:0][15:0] hi_run;
  logic [15:0] lo_run, both_run, rise_run, len_run, sw_run;

  // Strapped polarity and fault comparator outputs
  assign output_polarity_in = pol_set;
  assign fault_trip_in = fault_set;
  assign hi_act = {pins[1], pins[3], pins[5]} ~^ {3{output_polarity_in}};
  assign lo_act = {pins[0], pins[2], pins[4]} ~^ {3{output_polarity_in}};

  initial begin
    {sync_q, hi_q, tev_cnt, cycles, sw_run, sw_last} = '0;
    {hi_run, lo_run, both_run, rise_run, len_run} = '0;
  end

  // Per cycle meters, restarted on each sync rise
  always @(posedge hclk) begin
    sync_q <= sync;
    hi_q <= hi_act[0];
    tev_cnt <= tev_cnt + {15'h0, trip_event};
    sw_run <= sync ? sw_run + 16'd1 : 16'h0;
    if (sync_q && !sync) begin
      sw_last <= sw_run;
    end
    if (sync && !sync_q) begin
      hi_last <= hi_run;
      {lo_last, both_last, rise_last, len_last} <= {lo_run, both_run, rise_run, len_run};
      cycles <= cycles + 16'd1;
      for (int i = 0; i < 3; i++) hi_run[i] <= {15'h0, hi_act[i]};
      lo_run <= {15'h0, lo_act[0]};
      both_run <= {15'h0, |(hi_act & lo_act)};
      rise_run <= {15'h0, hi_act[0] && !hi_q};
      len_run <= 16'd1;
    end else begin
      for (int i = 0; i < 3; i++) hi_run[i] <= hi_run[i] + {15'h0, hi_act[i]};
      lo_run <= lo_run + {15'h0, lo_act[0]};
      both_run <= both_run + {15'h0, |(hi_act & lo_act)};
      rise_run <= rise_run + {15'h0, hi_act[0] && !hi_q};
      len_run <= len_run + 16'd1;
    end
  end
endmodule : tcpwm_drive_model

/* File: tb/three_phase_center_pwm_bench.sv */
// Self-checking bench of the PWM core: table of waveforms, then edge cases.
// Assumes the core's assertions live in its own files; drive model beside it.
module three_phase_center_pwm_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] p, dt, pd, d;
    logic [15:0] hi, lo;
  } tcpwm_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic pol, trip_n, pol_set, fault_set, sync, tev;
  logic ah, al, bh, bl, ch, cl;
  logic [2:0][15:0] hi_last;
  logic [15:0] lo_last, both_last, rise_last, len_last, sw_last, tev_cnt, cycles, n;
  int failures, compares, waits;
  // Duties inside the safe limit except the two saturation rows
  tcpwm_row_t rows [5] = '{'{12'd8, 12'd1, 12'd0, 12'd4, 16'd6, 16'd6},
    '{12'd20, 12'd2, 12'd0, 12'd10, 16'd16, 16'd16},
    '{12'd20, 12'd2, 12'd5, 12'd6, 16'd0, 16'd40},
    '{12'd20, 12'd2, 12'd5, 12'd17, 16'd40, 16'd0},
    '{12'd16, 12'd0, 12'd0, 12'd8, 16'd16, 16'd16}};

  tcpwm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .fault_trip_in(trip_n), .output_polarity_in(pol), .phase_a_high_out(ah),
    .phase_a_low_out(al), .phase_b_high_out(bh), .phase_b_low_out(bl),
    .phase_c_high_out(ch), .phase_c_low_out(cl), .cycle_sync_out(sync),
    .trip_event_out(tev));
  tcpwm_drive_model model (.hclk(hclk), .pol_set(pol_set), .fault_set(fault_set),
    .pins({ah, al, bh, bl, ch, cl}), .sync(sync), .trip_event(tev),
    .output_polarity_in(pol), .fault_trip_in(trip_n), .hi_last(hi_last),
    .lo_last(lo_last), .both_last(both_last), .rise_last(rise_last),
    .len_last(len_last), .sw_last(sw_last), .tev_cnt(tev_cnt), .cycles(cycles));

  // 50 MHz clock
  always #10 hclk = ~hclk;

  // Verdict and end of run
  task automatic final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask : chk16

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  // Wait for ready at rising edges, counting any wait states
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    waits += k - 1;
  endtask : wait_ready

  // Single word write: address phase, then data phase
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask : bus_write

  // Single word read, data taken at the data phase edge
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    wait_ready();
    d = hrdata;
  endtask : bus_read

  // Let cnt switching cycles start, bounded
  task automatic wait_sync(input int cnt);
    int lim;
    lim = 0;
    n = cycles + 16'(cnt);
    while (cycles != n && lim < 5000) begin
      @(posedge hclk);
      lim++;
    end
    if (lim >= 5000) begin
      failures++;
      $display("unexpected sync count: expected %0d seen %0d", n, cycles);
    end
  endtask : wait_sync

  // Period first, then deadtime, min pulse and all three duties
  task automatic prog(input logic [11:0] p, dt, pd, d);
    bus_write(8'h00, {20'h0, p});
    bus_write(8'h04, {20'h0, dt});
    bus_write(8'h08, {20'h0, pd});
    for (int i = 0; i < 3; i++) bus_write(8'h10 + 8'(4 * i), {20'h0, d});
  endtask : prog

  // Three phases, phase A low side and pair overlap of the last cycle
  task automatic check_run(input logic [15:0] hi, lo);
    for (int i = 0; i < 3; i++) chk16("high side clocks", hi, hi_last[i]);
    chk16("low side clocks", lo, lo_last);
    chk16("overlap clocks", 16'd0, both_last);
  endtask : check_run

  // Watchdog: whole run needs well under a millisecond
  initial begin
    #1ms;
    failures++;
    $display("unexpected hang: watchdog expired");
    final_report();
  end

  initial begin
    {hclk, hresetn, hwrite, failures, compares, waits} = '0;
    {haddr, hwdata, htrans} = '0;
    {hsel, pol_set, fault_set} = 3'b111;
    hsize = 3'b010;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus_read(8'h1c, rd);
    chk32("segment reset", 32'h0, rd);
    bus_read(8'h40, rd);
    chk32("unmapped read", 32'h0, rd);
    $display("test reset done");
    foreach (rows[i]) begin
      prog(rows[i].p, rows[i].dt, rows[i].pd, rows[i].d);
      wait_sync(3);
      check_run(rows[i].hi, rows[i].lo);
      chk16("cycle length", {3'h0, rows[i].p, 1'b0}, len_last);
      chk16("sync width", 16'd2, sw_last);
      $display("test row %0d done", i);
    end
    bus_read(8'h00, rd);
    chk32("period readback", 32'd16, rd);
    prog(12'd20, 12'd2, 12'd0, 12'd10);
    wait_sync(2);
    bus_write(8'h10, 32'd6);
    wait_sync(3);
    chk16("partial duty update", 16'd16, hi_last[0]);
    bus_write(8'h14, 32'd6);
    bus_write(8'h18, 32'd6);
    wait_sync(3);
    chk16("full duty update", 16'd8, hi_last[0]);
    $display("test duty update done");
    bus_write(8'h1c, 32'h100);
    wait_sync(3);
    chk16("swapped high", 16'd24, hi_last[0]);
    chk16("swapped low", 16'd8, lo_last);
    bus_write(8'h1c, 32'h030);
    wait_sync(3);
    chk16("disabled high", 16'd0, hi_last[0]);
    chk16("disabled low", 16'd0, lo_last);
    bus_write(8'h1c, 32'h0);
    pol_set <= 1'b0;
    wait_sync(3);
    bus_read(8'h20, rd);
    chk32("polarity status", 32'h0, rd & 32'h4);
    check_run(16'd8, 16'd24);
    pol_set <= 1'b1;
    $display("test segment and polarity done");
    bus_write(8'h0c, 32'h100);
    wait_sync(3);
    chk16("chopped turn-ons", 16'd1, {15'h0, rise_last > 16'd1});
    bus_write(8'h0c, 32'h0);
    wait_sync(3);
    chk16("unchopped turn-ons", 16'd1, rise_last);
    $display("test chopping done");
    fault_set <= 1'b0;
    repeat (8) @(posedge hclk);
    chk16("trip events", 16'd1, tev_cnt);
    chk16("pins in trip", 16'd0, {10'h0, ah, al, bh, bl, ch, cl});
    fault_set <= 1'b1;
    repeat (8) @(posedge hclk);
    bus_read(8'h00, rd);
    chk32("period after trip", 32'h0, rd);
    n = cycles;
    repeat (100) @(posedge hclk);
    chk16("syncs after trip", n, cycles);
    prog(12'd20, 12'd2, 12'd0, 12'd6);
    wait_sync(3);
    check_run(16'd8, 16'd24);
    chk16("bus wait states", 16'd0, 16'(waits));
    chk16("bus response", 16'd0, {15'h0, hresp});
    $display("test trip done");
    final_report();
  end
endmodule : three_phase_center_pwm_bench
